// [rtl/tls_analog_scale.sv]
// Linear scaler from the analog limit code to a torque percentage.
`timescale 1ns/100ps
module tls_analog_scale
#(
	parameter int ADC_W = 10
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [ADC_W-1:0] analog_limit_input,
	output logic [7:0] analog_pct
);

	// Full-scale code stands for 10 V; integer division truncates toward zero.
	localparam logic [ADC_W-1:0] FULL_CODE = {ADC_W{1'b1}};
	logic [ADC_W+7:0] product;
	logic [ADC_W+7:0] quotient;
	logic [7:0] analog_pct_reg;

	assign product = (ADC_W+8)'(analog_limit_input) * (ADC_W+8)'(tls_pkg::LIMIT_MAX_PCT);
	assign quotient = product / (ADC_W+8)'(FULL_CODE);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			analog_pct_reg <= '0;
		else
			analog_pct_reg <= quotient[7:0];
	end

	assign analog_pct = analog_pct_reg;

	a_analog_full: assert property (@(posedge clk) disable iff (!arst_n)
		(analog_limit_input == FULL_CODE) |=> (analog_pct == tls_pkg::LIMIT_MAX_PCT))
		else $error("Full-scale analog input did not give 200 percent.");

endmodule

// [rtl/tls_limit_select.sv]
// Top of the torque-limit selector: source choice, quadrant, ceiling and status.
`timescale 1ns/100ps
module tls_limit_select
#(
	parameter int ADC_W = 10,
	parameter int NUM_IN = tls_pkg::NUM_IN_TERMINALS,
	parameter int NUM_OUT = tls_pkg::NUM_OUT_TERMINALS
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NUM_IN-1:0] input_terminal_pins,
	input wire logic [NUM_IN-1:0][7:0] input_terminal_function,
	input wire logic [NUM_OUT-1:0][7:0] output_terminal_function,
	input wire logic [7:0] limit_source_setting,
	input wire logic [7:0] control_method_setting,
	input wire logic [7:0] stored_limit_one,
	input wire logic [7:0] stored_limit_two,
	input wire logic [7:0] stored_limit_three,
	input wire logic [7:0] stored_limit_four,
	input wire logic [ADC_W-1:0] analog_limit_input,
	input wire logic [1:0] card_fitted,
	input wire logic [1:0][7:0] card_limit,
	input wire tls_pkg::tls_motor_t motor,
	output logic [7:0] torque_ceiling,
	output logic limiting_allowed,
	output logic limiting_active_output,
	output logic [NUM_OUT-1:0] output_terminals
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	tls_pkg::tls_flags_t flags;
	tls_pkg::tls_quad_t quad_reg;
	tls_pkg::tls_quad_t quad_next;
	logic [7:0] analog_pct;
	logic [3:0][7:0] lim_raw;
	logic [3:0][7:0] lim_c;
	logic [1:0] term_index;
	logic method_ok;
	logic eff_enable;
	logic [7:0] ceiling_reg;
	logic [7:0] ceiling_next;
	logic allowed_reg;
	logic active_reg;
	logic active_next;
	logic [NUM_OUT-1:0] out_term_reg;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	tls_terminal_map #(.NUM_IN(NUM_IN)) u_map
	(
		.clk(clk),
		.arst_n(arst_n),
		.input_terminal_pins(input_terminal_pins),
		.input_terminal_function(input_terminal_function),
		.flags(flags)
	);

	tls_analog_scale #(.ADC_W(ADC_W)) u_analog
	(
		.clk(clk),
		.arst_n(arst_n),
		.analog_limit_input(analog_limit_input),
		.analog_pct(analog_pct)
	);

	// ----------------------------------------
	// Stored limits
	// ----------------------------------------
	// Settings above 200 percent are clamped so a bad setting cannot raise the ceiling.
	assign lim_raw = {stored_limit_four, stored_limit_three, stored_limit_two, stored_limit_one};

	genvar k;
	generate
		for (k = 0; k < 4; k++)
		begin : g_clamp
			assign lim_c[k] = (lim_raw[k] > tls_pkg::LIMIT_MAX_PCT) ?
				tls_pkg::LIMIT_MAX_PCT : lim_raw[k];
		end
	endgenerate

	assign term_index = {flags.limit_select_bit1, flags.limit_select_bit0};
	assign eff_enable = !flags.enable_assigned || flags.limit_enable_input;
	assign method_ok = (control_method_setting == tls_pkg::METHOD_SLV) ||
		(control_method_setting == tls_pkg::METHOD_SLV_ZERO) ||
		(control_method_setting == tls_pkg::METHOD_VECTOR);

	// ----------------------------------------
	// Operating quadrant
	// ----------------------------------------
	// Driving when torque and speed share a sign, regenerating when they differ.
	always_comb
	begin
		case ({motor.speed_reverse, motor.torque_reverse})
			2'b00: quad_next = tls_pkg::QUAD_FWD_DRIVE;
			2'b10: quad_next = tls_pkg::QUAD_REV_REGEN;
			2'b11: quad_next = tls_pkg::QUAD_REV_DRIVE;
			2'b01: quad_next = tls_pkg::QUAD_FWD_REGEN;
			default: quad_next = tls_pkg::QUAD_FWD_DRIVE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			quad_reg <= tls_pkg::QUAD_FWD_DRIVE;
		else
			quad_reg <= quad_next;
	end

	// ----------------------------------------
	// Ceiling selection
	// ----------------------------------------
	always_comb
	begin
		ceiling_next = tls_pkg::LIMIT_MAX_PCT;
		if (method_ok)
		begin
			case (limit_source_setting)
				tls_pkg::SRC_QUAD:
				begin
					if (eff_enable)
					begin
						case (quad_reg)
							tls_pkg::QUAD_FWD_DRIVE: ceiling_next = lim_c[0];
							tls_pkg::QUAD_REV_REGEN: ceiling_next = lim_c[1];
							tls_pkg::QUAD_REV_DRIVE: ceiling_next = lim_c[2];
							tls_pkg::QUAD_FWD_REGEN: ceiling_next = lim_c[3];
							default: ceiling_next = tls_pkg::LIMIT_MAX_PCT;
						endcase
					end
				end
				tls_pkg::SRC_TERM:
				begin
					if (eff_enable)
						ceiling_next = lim_c[term_index];
				end
				tls_pkg::SRC_ANALOG: ceiling_next = analog_pct;
				tls_pkg::SRC_CARD1:
				begin
					if (card_fitted[0])
						ceiling_next = card_limit[0];
				end
				tls_pkg::SRC_CARD2:
				begin
					if (card_fitted[1])
						ceiling_next = card_limit[1];
				end
				default: ceiling_next = tls_pkg::LIMIT_MAX_PCT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ceiling_reg <= tls_pkg::CEILING_RST;
		else
			ceiling_reg <= ceiling_next;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			allowed_reg <= 1'b0;
		else
			allowed_reg <= method_ok;
	end

	// ----------------------------------------
	// Limiting status
	// ----------------------------------------
	// Status compares against the ceiling in force, so it trails the ceiling by one cycle.
	assign active_next = allowed_reg && (motor.torque_demand >= ceiling_reg);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			active_reg <= 1'b0;
		else
			active_reg <= active_next;
	end

	genvar j;
	generate
		for (j = 0; j < NUM_OUT; j++)
		begin : g_out
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					out_term_reg[j] <= 1'b0;
				else
					out_term_reg[j] <= active_next &&
						(output_terminal_function[j] == tls_pkg::FN_LIMITING_STATUS);
			end
		end
	endgenerate

	assign torque_ceiling = ceiling_reg;
	assign limiting_allowed = allowed_reg;
	assign limiting_active_output = active_reg;
	assign output_terminals = out_term_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_default_ceiling: assert property (
		(method_ok && flags.enable_assigned && !flags.limit_enable_input &&
		(limit_source_setting == tls_pkg::SRC_QUAD || limit_source_setting == tls_pkg::SRC_TERM))
		|=> (ceiling_reg == tls_pkg::LIMIT_MAX_PCT))
		else $error("Ceiling is not 200 percent while enable is off.");

	a_quad_fwd_drive: assert property (
		(method_ok && eff_enable && limit_source_setting == tls_pkg::SRC_QUAD &&
		quad_reg == tls_pkg::QUAD_FWD_DRIVE) |=> (ceiling_reg == $past(lim_c[0])))
		else $error("Forward driving did not use limit one.");

	a_quad_rev_regen: assert property (
		(method_ok && eff_enable && limit_source_setting == tls_pkg::SRC_QUAD &&
		quad_reg == tls_pkg::QUAD_REV_REGEN) |=> (ceiling_reg == $past(lim_c[1])))
		else $error("Reverse regenerating did not use limit two.");

	a_quad_follow: assert property (
		(motor.speed_reverse && !motor.torque_reverse) |=> (quad_reg == tls_pkg::QUAD_REV_REGEN))
		else $error("Quadrant did not follow reverse speed with forward torque.");

	a_term_index: assert property (
		(method_ok && eff_enable && limit_source_setting == tls_pkg::SRC_TERM &&
		flags.limit_select_bit0 && !flags.limit_select_bit1)
		|=> (ceiling_reg == $past(lim_c[1])))
		else $error("Select bit0 alone did not pick limit two.");

	a_analog_path: assert property (
		(method_ok && limit_source_setting == tls_pkg::SRC_ANALOG)
		|=> (ceiling_reg == $past(analog_pct)))
		else $error("Analog mode ceiling does not follow the scaled input.");

	a_method_gate: assert property (
		!method_ok |=> (ceiling_reg == tls_pkg::LIMIT_MAX_PCT) ##1 !active_reg)
		else $error("Limiting acted under a control method without limiting.");

	a_card_absent: assert property (
		(method_ok && limit_source_setting == tls_pkg::SRC_CARD1 && !card_fitted[0])
		|=> (ceiling_reg == tls_pkg::LIMIT_MAX_PCT))
		else $error("Missing card still set the ceiling.");

	a_status_cause: assert property (
		active_reg |-> $past(allowed_reg && motor.torque_demand >= ceiling_reg))
		else $error("Limiting status raised without cause.");

	a_status_term: assert property (
		(output_terminal_function[0] == tls_pkg::FN_LIMITING_STATUS && active_next)
		|=> (out_term_reg[0] && active_reg))
		else $error("Status terminal did not follow limiting.");

	a_ceiling_range: assert property (
		(limit_source_setting != tls_pkg::SRC_CARD1 && limit_source_setting != tls_pkg::SRC_CARD2)
		|=> (ceiling_reg <= tls_pkg::LIMIT_MAX_PCT))
		else $error("Ceiling above 200 percent.");

	c_quad_mode: cover property (method_ok && limit_source_setting == tls_pkg::SRC_QUAD &&
		quad_reg == tls_pkg::QUAD_FWD_REGEN ##1 active_reg);
	c_term_mode: cover property (method_ok && limit_source_setting == tls_pkg::SRC_TERM &&
		term_index == 2'b11 && eff_enable);
	c_analog_mode: cover property (method_ok && limit_source_setting == tls_pkg::SRC_ANALOG ##2
		active_reg);
	c_enable_off: cover property (flags.enable_assigned && !flags.limit_enable_input && method_ok);

endmodule

// [rtl/tls_pkg.sv]
// Package with constants and carrier types for the torque-limit selector.
package tls_pkg;

	// ----------------------------------------
	// Setting codes
	// ----------------------------------------
	localparam logic [7:0] SRC_QUAD = 8'h00;
	localparam logic [7:0] SRC_TERM = 8'h01;
	localparam logic [7:0] SRC_ANALOG = 8'h02;
	localparam logic [7:0] SRC_CARD1 = 8'h03;
	localparam logic [7:0] SRC_CARD2 = 8'h04;

	localparam logic [7:0] METHOD_SLV = 8'h03;
	localparam logic [7:0] METHOD_SLV_ZERO = 8'h04;
	localparam logic [7:0] METHOD_VECTOR = 8'h05;

	// Input functions 40, 41, 42 and output function 10, in decimal.
	localparam logic [7:0] FN_LIMIT_ENABLE = 8'h28;
	localparam logic [7:0] FN_SELECT_BIT0 = 8'h29;
	localparam logic [7:0] FN_SELECT_BIT1 = 8'h2a;
	localparam logic [7:0] FN_LIMITING_STATUS = 8'h0a;

	// ----------------------------------------
	// Limits and timing
	// ----------------------------------------
	// Percentages are carried as whole percent; 200 percent is the ceiling.
	localparam logic [7:0] LIMIT_MAX_PCT = 8'hc8;
	localparam logic [7:0] CEILING_RST = 8'hc8;
	localparam int ANALOG_FULL_MV = 10000;
	localparam int SYNC_STAGES = 2;
	localparam int NUM_IN_TERMINALS = 8;
	localparam int NUM_OUT_TERMINALS = 5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		QUAD_FWD_DRIVE = 4'b0001,
		QUAD_REV_REGEN = 4'b0010,
		QUAD_REV_DRIVE = 4'b0100,
		QUAD_FWD_REGEN = 4'b1000
	} tls_quad_t;

	typedef struct packed
	{
		logic speed_reverse;
		logic torque_reverse;
		logic [7:0] torque_demand;
	} tls_motor_t;

	typedef struct packed
	{
		logic enable_assigned;
		logic limit_enable_input;
		logic limit_select_bit1;
		logic limit_select_bit0;
	} tls_flags_t;

endpackage

// [rtl/tls_terminal_map.sv]
// Input terminal synchroniser and function decode for the torque-limit selector.
`timescale 1ns/100ps
module tls_terminal_map
#(
	parameter int NUM_IN = 8
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NUM_IN-1:0] input_terminal_pins,
	input wire logic [NUM_IN-1:0][7:0] input_terminal_function,
	output tls_pkg::tls_flags_t flags
);

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// Pins are asynchronous to clk, so two flops stand before any decode.
	logic [NUM_IN-1:0] sync1_reg;
	logic [NUM_IN-1:0] sync2_reg;
	logic [NUM_IN-1:0] hit_en;
	logic [NUM_IN-1:0] hit_b0;
	logic [NUM_IN-1:0] hit_b1;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= input_terminal_pins;
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// Function decode
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_IN; i++)
		begin : g_term
			assign hit_en[i] = input_terminal_function[i] == tls_pkg::FN_LIMIT_ENABLE;
			assign hit_b0[i] = input_terminal_function[i] == tls_pkg::FN_SELECT_BIT0;
			assign hit_b1[i] = input_terminal_function[i] == tls_pkg::FN_SELECT_BIT1;
		end
	endgenerate

	assign flags.enable_assigned = |hit_en;
	assign flags.limit_enable_input = |(hit_en & sync2_reg);
	assign flags.limit_select_bit0 = |(hit_b0 & sync2_reg);
	assign flags.limit_select_bit1 = |(hit_b1 & sync2_reg);

	a_sync_latency: assert property (@(posedge clk) disable iff (!arst_n)
		(hit_en[0] && $past(input_terminal_pins[0], 2)) |-> flags.limit_enable_input)
		else $error("Enable terminal not seen two cycles after the pin.");

endmodule

// [tb/tls_controller_model.sv]
// Model of the external controller that drives the input terminals.
`timescale 1ns/100ps
module tls_controller_model
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable_cmd,
	input wire logic sel0_cmd,
	input wire logic sel1_cmd,
	output logic [7:0] input_terminal_pins
);
	logic [4:0] spare_reg;

	// Overload restriction at low speed stays with the controller, outside this block.

	// Terminals four to eight are unassigned; they toggle every cycle so that a decoder
	// which ignores the function codes cannot hide behind a steady level.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			spare_reg <= 5'h0a;
		else
			spare_reg <= ~spare_reg;
	end

	assign input_terminal_pins = {spare_reg, sel1_cmd, sel0_cmd, enable_cmd};
endmodule

// [tb/tls_limit_select_bench.sv]
// Self-checking bench for the torque-limit selector.
`timescale 1ns/100ps
module tls_limit_select_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk;
	logic arst_n;
	logic [7:0] pins;
	logic [7:0][7:0] in_fn;
	logic [4:0][7:0] out_fn;
	logic [7:0] src;
	logic [7:0] method;
	logic [3:0][7:0] lim;
	logic [9:0] analog;
	logic [1:0] card_fitted;
	logic [1:0][7:0] card_limit;
	tls_pkg::tls_motor_t motor;
	logic en_cmd;
	logic sel0_cmd;
	logic sel1_cmd;
	logic [7:0] ceiling;
	logic allowed;
	logic active;
	logic [4:0] out_terms;
	int fail_count;
	int cmp_count;

	tls_controller_model i_tls_controller_model
	(
		.clk(clk),
		.arst_n(arst_n),
		.enable_cmd(en_cmd),
		.sel0_cmd(sel0_cmd),
		.sel1_cmd(sel1_cmd),
		.input_terminal_pins(pins)
	);

	tls_limit_select #(.ADC_W(10)) i_tls_limit_select
	(
		.clk(clk),
		.arst_n(arst_n),
		.input_terminal_pins(pins),
		.input_terminal_function(in_fn),
		.output_terminal_function(out_fn),
		.limit_source_setting(src),
		.control_method_setting(method),
		.stored_limit_one(lim[0]),
		.stored_limit_two(lim[1]),
		.stored_limit_three(lim[2]),
		.stored_limit_four(lim[3]),
		.analog_limit_input(analog),
		.card_fitted(card_fitted),
		.card_limit(card_limit),
		.motor(motor),
		.torque_ceiling(ceiling),
		.limiting_allowed(allowed),
		.limiting_active_output(active),
		.output_terminals(out_terms)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_pct(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	// The slowest path is pins to status, four edges; six leaves margin for all paths.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic sc_quad();
		logic [3:0][7:0] exp;
		exp = {8'h1e, 8'h14, 8'hc8, 8'h0a};
		for (int q = 0; q < 4; q++)
		begin
			@(posedge clk);
			motor.speed_reverse <= q[1];
			motor.torque_reverse <= q[0];
			settle();
			chk_pct(ceiling, exp[q]);
		end
	endtask

	task automatic sc_term();
		logic [3:0][7:0] exp;
		exp = {8'hc8, 8'h1e, 8'h14, 8'h0a};
		@(posedge clk);
		in_fn[0] <= tls_pkg::FN_LIMIT_ENABLE;
		in_fn[1] <= tls_pkg::FN_SELECT_BIT0;
		in_fn[2] <= tls_pkg::FN_SELECT_BIT1;
		src <= tls_pkg::SRC_TERM;
		settle();
		chk_pct(ceiling, 8'hc8);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			en_cmd <= 1'b1;
			sel0_cmd <= i[0];
			sel1_cmd <= i[1];
			motor.speed_reverse <= ~i[0];
			motor.torque_reverse <= i[1];
			settle();
			chk_pct(ceiling, exp[i]);
		end
		@(posedge clk);
		src <= tls_pkg::SRC_QUAD;
		motor <= '0;
		settle();
		chk_pct(ceiling, 8'h0a);
		@(posedge clk);
		en_cmd <= 1'b0;
		settle();
		chk_pct(ceiling, 8'hc8);
	endtask

	task automatic sc_analog();
		logic [2:0][9:0] codes;
		int e;
		codes = {10'h3ff, 10'h1ff, 10'h000};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			src <= tls_pkg::SRC_ANALOG;
			analog <= codes[i];
			settle();
			e = (int'(codes[i]) * 200) / 1023;
			chk_pct(ceiling, 8'(e));
		end
	endtask

	task automatic sc_card();
		@(posedge clk);
		src <= tls_pkg::SRC_CARD1;
		card_limit <= {8'h3c, 8'h32};
		card_fitted <= 2'b10;
		settle();
		chk_pct(ceiling, 8'hc8);
		@(posedge clk);
		card_fitted <= 2'b01;
		settle();
		chk_pct(ceiling, 8'h32);
		@(posedge clk);
		src <= tls_pkg::SRC_CARD2;
		card_fitted <= 2'b10;
		settle();
		chk_pct(ceiling, 8'h3c);
		@(posedge clk);
		src <= 8'h05;
		settle();
		chk_pct(ceiling, 8'hc8);
	endtask

	task automatic sc_method();
		logic a;
		@(posedge clk);
		src <= tls_pkg::SRC_QUAD;
		in_fn <= '0;
		out_fn[3] <= tls_pkg::FN_LIMITING_STATUS;
		out_fn[0] <= tls_pkg::FN_LIMITING_STATUS;
		motor <= {2'b00, 8'hff};
		for (int m = 0; m < 6; m++)
		begin
			@(posedge clk);
			method <= 8'(m);
			settle();
			a = (m >= 3);
			chk_flag(allowed, a);
			chk_pct(ceiling, a ? 8'h0a : 8'hc8);
			chk_flag(active, a);
			chk_pct({3'h0, out_terms}, {4'h0, a, 2'h0, a});
		end
		@(posedge clk);
		motor.torque_demand <= 8'h0a;
		settle();
		chk_flag(active, 1'b1);
		@(posedge clk);
		motor.torque_demand <= 8'h09;
		settle();
		chk_flag(active, 1'b0);
		chk_pct({3'h0, out_terms}, 8'h00);
	endtask

	task automatic sc_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		#1;
		chk_pct(ceiling, tls_pkg::CEILING_RST);
		chk_flag(allowed, 1'b0);
		chk_flag(active, 1'b0);
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		#200us;
		fail_count++;
		end_sim();
	end

	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		in_fn = '0;
		out_fn = '0;
		src = tls_pkg::SRC_QUAD;
		method = tls_pkg::METHOD_SLV;
		lim = {8'hfa, 8'h1e, 8'h14, 8'h0a};
		analog = 10'h000;
		card_fitted = 2'b00;
		card_limit = '0;
		motor = '0;
		en_cmd = 1'b0;
		sel0_cmd = 1'b0;
		sel1_cmd = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		sc_quad();
		sc_term();
		sc_analog();
		sc_card();
		sc_reset();
		sc_method();
		end_sim();
	end
endmodule
